// ### design/burst2_cio_sram_interface.v
// Command, late-write and read pipeline of a burst-of-two common-I/O SRAM.
// The two clock edges are modelled as two phases of clk_i: phase 0 stands for the
// main-clock edge, phase 1 for the complement edge. The memory is x18 with
// byte masks; nibble_mode_i narrows writes to the low eight bits; reads return all 18 bits.
`timescale 1ns/100ps
`default_nettype none
`include "burst2_sram_consts.vh"

module burst2_cio_sram_interface (
    // Clock and reset
    input  wire                  clk_i,
    input  wire                  rst_n_i,
    // Command and address pins
    input  wire [`ADDR_W-1:0]    sync_address_i,
    input  wire                  load_n_i,
    input  wire                  read_not_write_i,
    // Write masks, active low
    input  wire [`LANES-1:0]     byte_write_mask_n_i,
    input  wire [`NIB_LANES-1:0] nibble_write_mask_n_i,
    // Variant and static pins
    input  wire                  nibble_mode_i,
    input  wire                  dll_disable_n_i,
    input  wire                  termination_range_select_i,
    input  wire                  zq_too_weak_i,
    input  wire                  zq_too_strong_i,
    // Shared data bus, split into in, out and enable (enable low drives)
    input  wire [`DATA_W-1:0]    dq_i,
    output reg  [`DATA_W-1:0]    dq_o,
    output reg                   dq_oe_n_o,
    // Status outputs
    output reg                   read_data_valid_o,
    output reg                   phase_o,
    output reg                   dll_enable_o,
    output reg                   term_low_range_o,
    output reg  [`IMP_STEP_W-1:0] drive_code_o,
    output reg                   imp_eval_o
);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    reg [`ADDR_W-1:0]    addr_m_q, addr_s_q;
    reg                  ld_m_q, ld_s_q, rw_m_q, rw_s_q;
    reg [`LANES-1:0]     bw_m_q, bw_s_q;
    reg [`NIB_LANES-1:0] nw_m_q, nw_s_q;
    reg [`DATA_W-1:0]    dq_m_q, dq_s_q;
    reg [5:0]            misc_m_q, misc_s_q;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            addr_m_q <= {`ADDR_W{1'b0}};
            addr_s_q <= {`ADDR_W{1'b0}};
            ld_m_q   <= 1'b1;
            ld_s_q   <= 1'b1;
            rw_m_q   <= 1'b1;
            rw_s_q   <= 1'b1;
            bw_m_q   <= {`LANES{1'b1}};
            bw_s_q   <= {`LANES{1'b1}};
            nw_m_q   <= {`NIB_LANES{1'b1}};
            nw_s_q   <= {`NIB_LANES{1'b1}};
            dq_m_q   <= {`DATA_W{1'b0}};
            dq_s_q   <= {`DATA_W{1'b0}};
            misc_m_q <= 6'h0C;
            misc_s_q <= 6'h0C;
        end else begin
            addr_m_q <= sync_address_i;
            addr_s_q <= addr_m_q;
            ld_m_q   <= load_n_i;
            ld_s_q   <= ld_m_q;
            rw_m_q   <= read_not_write_i;
            rw_s_q   <= rw_m_q;
            bw_m_q   <= byte_write_mask_n_i;
            bw_s_q   <= bw_m_q;
            nw_m_q   <= nibble_write_mask_n_i;
            nw_s_q   <= nw_m_q;
            dq_m_q   <= dq_i;
            dq_s_q   <= dq_m_q;
            misc_m_q <= {zq_too_strong_i, zq_too_weak_i, termination_range_select_i,
                         dll_disable_n_i, nibble_mode_i, 1'b0};
            misc_s_q <= misc_m_q;
        end
    end

    wire nib_mode = misc_s_q[1];

    // ---------------------------------------------------------------
    // Phase and command decode
    // ---------------------------------------------------------------
    reg phase_q;
    wire main_edge = !phase_q;
    wire rd_cmd = main_edge && !ld_s_q && rw_s_q;
    wire wr_cmd = main_edge && !ld_s_q && !rw_s_q;
    // A high load_n is a deselect and leaves the pipeline idle.
    wire nop_cmd = main_edge && ld_s_q;

    // Pipeline slots one and two main cycles after the command.
    reg                rd1_q, rd2_q, wr1_q, wr2_q, off1_q, off2_q;
    reg [`ADDR_W-1:0]  rda1_q, rda2_q, wra1_q, wra2_q;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_q <= 1'b0;
            rd1_q   <= 1'b0;
            rd2_q   <= 1'b0;
            wr1_q   <= 1'b0;
            wr2_q   <= 1'b0;
            off1_q  <= 1'b0;
            off2_q  <= 1'b0;
            rda1_q  <= {`ADDR_W{1'b0}};
            rda2_q  <= {`ADDR_W{1'b0}};
            wra1_q  <= {`ADDR_W{1'b0}};
            wra2_q  <= {`ADDR_W{1'b0}};
        end else begin
            phase_q <= !phase_q;
            if (main_edge) begin
                // Sampled on every main edge so back-to-back commands work.
                rd1_q  <= rd_cmd;
                rda1_q <= addr_s_q;
                rd2_q  <= rd1_q;
                rda2_q <= rda1_q;
                wr1_q  <= wr_cmd;
                wra1_q <= addr_s_q;
                // Second slot keeps the address alive for the complement-edge beat.
                wr2_q  <= wr1_q;
                wra2_q <= wra1_q;
                off1_q <= nop_cmd || wr_cmd;
                off2_q <= off1_q;
            end
        end
    end

    // ---------------------------------------------------------------
    // Memory array, two beats per address
    // ---------------------------------------------------------------
    reg [`DATA_W-1:0] mem_b0 [0:(1<<`ADDR_W)-1];
    reg [`DATA_W-1:0] mem_b1 [0:(1<<`ADDR_W)-1];

    // Per-lane enables for the beat at hand, masks taken with the data.
    reg [`DATA_W-1:0] bit_en;
    genvar g;
    generate
        for (g = 0; g < `DATA_W; g = g + 1) begin : g_lane
            always @* begin
                if (nib_mode) begin
                    bit_en[g] = (g < 2*`NIB_W) ? !nw_s_q[g/`NIB_W] : 1'b0;
                end else begin
                    bit_en[g] = !bw_s_q[g/`LANE_W];
                end
            end
        end
    endgenerate

    // Beat one at the main edge after the command, beat two at the next half.
    wire wr_beat0 = wr1_q && main_edge;
    wire wr_beat1 = wr2_q && !main_edge;

    always @(posedge clk_i) begin
        if (wr_beat0) begin
            mem_b0[wra1_q] <= (mem_b0[wra1_q] & ~bit_en) | (dq_s_q & bit_en);
        end
        if (wr_beat1) begin
            mem_b1[wra2_q] <= (mem_b1[wra2_q] & ~bit_en) | (dq_s_q & bit_en);
        end
    end

    // ---------------------------------------------------------------
    // Read data out and driver enable
    // ---------------------------------------------------------------
    // Read data appears two main cycles after the command, beat one then two.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            dq_o              <= {`DATA_W{1'b0}};
            dq_oe_n_o         <= 1'b1;
            read_data_valid_o <= 1'b0;
        end else if (rd2_q) begin
            // Beat one leaves on the complement slot, beat two on the main slot after it.
            dq_o              <= main_edge ? mem_b1[rda2_q] : mem_b0[rda2_q];
            dq_oe_n_o         <= 1'b0;
            read_data_valid_o <= 1'b1;
        end else begin
            // Drivers go off for the slot of a no-op or write.
            dq_oe_n_o         <= off2_q ? 1'b1 : 1'b1;
            read_data_valid_o <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Static controls and impedance tracking
    // ---------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_o          <= 1'b0;
            dll_enable_o     <= 1'b1;
            term_low_range_o <= 1'b0;
        end else begin
            phase_o          <= phase_q;
            dll_enable_o     <= misc_s_q[2];
            term_low_range_o <= !misc_s_q[3];
        end
    end

    wire [`IMP_STEP_W-1:0] code_w;
    wire                   eval_w;

    impedance_tracker u_imp (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .too_weak_i   (misc_s_q[4]),
        .too_strong_i (misc_s_q[5]),
        .drive_code_o (code_w),
        .eval_o       (eval_w)
    );

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            drive_code_o <= `IMP_RESET_CODE;
            imp_eval_o   <= 1'b0;
        end else begin
            drive_code_o <= code_w;
            imp_eval_o   <= eval_w;
        end
    end

endmodule // burst2_cio_sram_interface
`default_nettype wire

// ### design/burst2_sram_consts.vh
// Constants shared by the burst-of-two common-I/O SRAM interface.
`ifndef BURST2_SRAM_CONSTS_VH
`define BURST2_SRAM_CONSTS_VH

`define ADDR_W          8
`define DATA_W          18
`define LANE_W          9
`define LANES           2
`define NIB_W           4
`define NIB_LANES       2
`define CLK_PERIOD_NS   50
`define CAL_INTERVAL_US 1
`define CAL_INTERVAL_CYC ((`CAL_INTERVAL_US * 1000) / `CLK_PERIOD_NS)
`define IMP_STEP_W      5
`define IMP_RESET_CODE  5'h10

`endif

// ### design/impedance_tracker.v
// Periodic output-driver impedance evaluation with one-step adjustment.
`timescale 1ns/100ps
`default_nettype none
`include "burst2_sram_consts.vh"

module impedance_tracker (
    // Clock and reset
    input  wire                   clk_i,
    input  wire                   rst_n_i,
    // Comparator result from the reference pin, already synchronised
    input  wire                   too_weak_i,
    input  wire                   too_strong_i,
    // Driver strength code and evaluation strobe
    output reg  [`IMP_STEP_W-1:0] drive_code_o,
    output reg                    eval_o
);

    reg [15:0] cnt_q;

    // Free-running so that the driver keeps tracking voltage and temperature.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q        <= 16'h0000;
            eval_o       <= 1'b0;
            drive_code_o <= `IMP_RESET_CODE;
        end else begin
            eval_o <= 1'b0;
            if (cnt_q == `CAL_INTERVAL_CYC - 1) begin
                cnt_q  <= 16'h0000;
                eval_o <= 1'b1;
                // Binary weighted code moves one unit at most per evaluation.
                if (too_weak_i && !too_strong_i && drive_code_o != 5'h1F) begin
                    drive_code_o <= drive_code_o + 5'h01;
                end else if (too_strong_i && !too_weak_i && drive_code_o != 5'h00) begin
                    drive_code_o <= drive_code_o - 5'h01;
                end
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

endmodule // impedance_tracker
`default_nettype wire

// ### verif/burst2_cio_sram_interface_test.sv
// Self-checking bench for the burst-of-two SRAM interface.
`timescale 1ns/100ps
`default_nettype none
`include "burst2_sram_consts.vh"
module burst2_cio_sram_interface_test;
    typedef struct {logic nib, rw; logic [7:0] a; logic [17:0] d1, d2; logic [1:0] m1, m2;} row_t;
    logic        clk_i, rst_n_i, load_n_i, read_not_write_i, nibble_mode_i, dll_disable_n_i;
    logic        termination_range_select_i, zq_too_weak_i, zq_too_strong_i;
    logic [7:0]  sync_address_i;
    logic [1:0]  byte_write_mask_n_i, nibble_write_mask_n_i;
    wire  [17:0] dq_i, dq_o;
    wire         dq_oe_n_o, read_data_valid_o, phase_o, dll_enable_o, term_low_range_o, imp_eval_o;
    wire  [4:0]  drive_code_o;
    logic [17:0] got_q[$], exp_q[$];
    logic [4:0]  c0, c1;
    int          bad_count = 0, comparisons = 0, cycles = 0, n;
    // Read rows carry the data that the read must return.
    row_t rows [7] = '{'{0, 0, 8'h03, 18'h15555, 18'h2AAAA, 2'h0, 2'h0},
        '{0, 0, 8'h03, 18'h3FFFF, 18'h3FFFF, 2'h2, 2'h1},
        '{0, 0, 8'h07, 18'h00001, 18'h20000, 2'h0, 2'h0},
        '{0, 0, 8'h07, 18'h3FFFF, 18'h3FFFF, 2'h3, 2'h3},
        '{1, 0, 8'h07, 18'h3FFFF, 18'h3FF5A, 2'h1, 2'h0},
        '{0, 1, 8'h03, 18'h155FF, 18'h3FEAA, 2'h0, 2'h0},
        '{0, 1, 8'h07, 18'h000F1, 18'h2005A, 2'h0, 2'h0}};
    burst2_cio_sram_interface u_dut (.clk_i, .rst_n_i, .sync_address_i, .load_n_i,
        .read_not_write_i, .byte_write_mask_n_i, .nibble_write_mask_n_i, .nibble_mode_i,
        .dll_disable_n_i, .termination_range_select_i, .zq_too_weak_i, .zq_too_strong_i, .dq_i,
        .dq_o, .dq_oe_n_o, .read_data_valid_o, .phase_o, .dll_enable_o, .term_low_range_o,
        .drive_code_o, .imp_eval_o);
    sram_ctrl_model u_ctl (.clk_i, .phase_i(phase_o), .dev_dq_i(dq_o), .dev_oe_n_i(dq_oe_n_o),
        .addr_o(sync_address_i), .load_n_o(load_n_i), .rnw_o(read_not_write_i),
        .bmask_o(byte_write_mask_n_i), .nmask_o(nibble_write_mask_n_i), .nib_o(nibble_mode_i),
        .bus_o(dq_i));
    task automatic check(input logic [17:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic idle(input int k);
        repeat (k) u_ctl.cmd(1, 0, 8'h00, 18'h0, 18'h0, 2'h0, 2'h0, 0);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            bad_count++;
            end_of_test();
        end
    end
    always @(negedge clk_i) if (read_data_valid_o === 1'b1) got_q.push_back(dq_o);
    initial begin
        {rst_n_i, dll_disable_n_i, termination_range_select_i, zq_too_weak_i, zq_too_strong_i} = 5'h0C;
        repeat (16) @(negedge clk_i);
        check({dq_oe_n_o, read_data_valid_o, dll_enable_o, term_low_range_o, drive_code_o}, 9'h150);
        rst_n_i = 1'b1;
        for (int i = 0; i < 7; i++) begin
            // Put two deselect commands between rows that change direction or nibble mode.
            if (i > 0 && {rows[i].rw, rows[i].nib} != {rows[i-1].rw, rows[i-1].nib}) idle(2);
            if (rows[i].rw) exp_q.push_back(rows[i].d1);
            if (rows[i].rw) exp_q.push_back(rows[i].d2);
            u_ctl.cmd(0, rows[i].rw, rows[i].a, rows[i].d1, rows[i].d2, rows[i].m1, rows[i].m2, rows[i].nib);
        end
        idle(6);
        check(18'(got_q.size()), 18'(exp_q.size()));
        foreach (exp_q[i]) check(got_q[i], exp_q[i]);
        {dll_disable_n_i, termination_range_select_i} = 2'b00;
        repeat (6) @(negedge clk_i);
        check({dll_enable_o, term_low_range_o}, 2'b01);
        termination_range_select_i = 1'b1;
        zq_too_weak_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check(term_low_range_o, 1'b0);
        n = 0;
        while (imp_eval_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        repeat (10) @(negedge clk_i);
        c0 = drive_code_o;
        n = 0;
        repeat (100) @(negedge clk_i) n += (imp_eval_o === 1'b1);
        c1 = drive_code_o;
        check(18'(n), 18'd5);
        check(c1 > c0 ? c1 - c0 : c0 - c1, 5'h05);
        end_of_test();
    end
endmodule // burst2_cio_sram_interface_test
bind burst2_cio_sram_interface sram_port_monitor u_mon (.clk_i, .rst_n_i, .load_n_i,
    .read_not_write_i, .dll_disable_n_i, .termination_range_select_i, .dq_oe_n_o,
    .read_data_valid_o, .phase_o, .dll_enable_o, .term_low_range_o, .drive_code_o, .imp_eval_o);
`default_nettype wire

// ### verif/sram_ctrl_model.sv
// Memory controller model: commands, late-write beats and bus resolution.
`timescale 1ns/100ps
`default_nettype none
`include "burst2_sram_consts.vh"
module sram_ctrl_model (
    // Clock and device side
    input  wire logic                clk_i,
    input  wire logic                phase_i,
    input  wire logic [`DATA_W-1:0]  dev_dq_i,
    input  wire logic                dev_oe_n_i,
    // Pins toward the device
    output var  logic [`ADDR_W-1:0]  addr_o,
    output var  logic                load_n_o,
    output var  logic                rnw_o,
    output var  logic [1:0]          bmask_o,
    output var  logic [1:0]          nmask_o,
    output var  logic                nib_o,
    output wire logic [`DATA_W-1:0]  bus_o
);
    logic [17:0] drv_q = 18'h0;
    logic        pend_q = 1'b0;
    logic [17:0] pd1, pd2;
    logic [1:0]  pm1, pm2;
    initial {addr_o, load_n_o, rnw_o, bmask_o, nmask_o, nib_o} = {8'h00, 1'b1, 1'b0, 4'h0, 1'b0};
    assign bus_o = (dev_oe_n_i === 1'b0) ? dev_dq_i : drv_q;
    // Outside its own beats the bus shows device read data or flipped data, and holds its value once commands stop.
    task automatic beat(input logic [17:0] d, input logic [1:0] m);
        drv_q = pend_q ? d : ~drv_q;
        bmask_o = !pend_q ? 2'h0 : nib_o ? 2'h3 : m;
        nmask_o = !pend_q ? 2'h0 : nib_o ? m : 2'h3;
    endtask
    task automatic cmd(input logic ld, rw, input logic [7:0] a, input logic [17:0] d1, d2,
                       input logic [1:0] m1, m2, input logic nib);
        @(negedge clk_i);
        while (phase_i !== 1'b1) @(negedge clk_i);
        load_n_o = ld;
        rnw_o = ld ? ~rnw_o : rw;
        addr_o = ld ? ~addr_o : a;
        if (!ld) nib_o = nib;
        beat(pd1, pm1);
        @(negedge clk_i);
        beat(pd2, pm2);
        pend_q = !ld && !rw;
        {pd1, pd2, pm1, pm2} = {d1, d2, m1, m2};
    endtask
endmodule // sram_ctrl_model
`default_nettype wire

// ### verif/sram_port_monitor.sv
// Port-level assertions for the burst-of-two SRAM interface.
`timescale 1ns/100ps
`default_nettype none
`include "burst2_sram_consts.vh"
module sram_port_monitor (
    // Clock, reset and pins
    input wire logic                   clk_i,
    input wire logic                   rst_n_i,
    input wire logic                   load_n_i,
    input wire logic                   read_not_write_i,
    input wire logic                   dll_disable_n_i,
    input wire logic                   termination_range_select_i,
    // Device outputs
    input wire logic                   dq_oe_n_o,
    input wire logic                   read_data_valid_o,
    input wire logic                   phase_o,
    input wire logic                   dll_enable_o,
    input wire logic                   term_low_range_o,
    input wire logic [`IMP_STEP_W-1:0] drive_code_o,
    input wire logic                   imp_eval_o
);
    // ------------------------------
    // Command as the core sees it
    // ------------------------------
    // Pins reach the core two edges late and count only in main-edge slots.
    logic [1:0] ld_q;
    logic [1:0] rw_q;
    wire        rd_take = !ld_q[1] && rw_q[1] && phase_o;
    wire        wr_take = !ld_q[1] && !rw_q[1] && phase_o;
    wire        ds_take = ld_q[1] && phase_o;
    always @(posedge clk_i) begin
        ld_q <= {ld_q[0], load_n_i};
        rw_q <= {rw_q[0], read_not_write_i};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_read_two_beats: assert property (
        rd_take |-> ##4 read_data_valid_o ##1 read_data_valid_o) else $error("read beats missing");
    a_beat_cause: assert property (
        $rose(read_data_valid_o) |-> $past(rd_take, 4)) else $error("read beat without read");
    a_write_off: assert property (
        wr_take |-> ##4 dq_oe_n_o [*2]) else $error("driver on after write");
    a_deselect_off: assert property (
        ds_take |-> ##4 dq_oe_n_o [*2]) else $error("driver on after deselect");
    a_code_step: assert property (
        drive_code_o == $past(drive_code_o) || drive_code_o == $past(drive_code_o) + 5'h01
        || drive_code_o == $past(drive_code_o) - 5'h01) else $error("code jumped");
    a_eval_period: assert property (
        imp_eval_o |-> ##1 !imp_eval_o [*8] ##12 imp_eval_o) else $error("eval period wrong");
    a_dll_off: assert property (
        $fell(dll_disable_n_i) |-> ##[1:4] !dll_enable_o) else $error("loop not disabled");
    a_term_low: assert property (
        $fell(termination_range_select_i) |-> ##[1:4] term_low_range_o) else $error("range wrong");
endmodule // sram_port_monitor
`default_nettype wire
